// File: verilog/diefl_top.sv
/*
  drive digital i/o, enable gate and fault relay logic with an
  avalon-mm register slave.
  assumes asynchronous pin inputs, each passed through a two-stage
  synchroniser, and fault and warning lines from the drive.
*/
// How it works
// - two fast inputs sampled every 2 us
// - inputs three to seven sampled every 250 us
// - all inputs unassigned and inactive after reset
// - input eight fixed to enable, not assignable
// - assigned function sets each input's active level
// - input functions act only after save command
// - output stage needs high hardware enable input
// - no enable without safe torque off asserted
// - enable low forces output stage off
// - software enable anded in, may be permanent
// - output function acts only after save command
// - relay mode: no fault, or fault-free and enabled
// - heating limit and regen never touch relay
// - any fault opens relay and stops stage
`timescale 1ns/100ps
`include "diefl_consts.svh"

module diefl_top #(
  parameter int unsigned SLOW_CYC =
    `DIEFL_SLOW_UPD_NS / `DIEFL_CLK_PERIOD_NS
) (
  input  wire logic                SYS_CLK_I,
  input  wire logic                ARST_N_I,
  input  wire diefl_pkg::diefl_addr_t AVS_ADDRESS_I,
  input  wire logic                AVS_READ_I,
  input  wire logic                AVS_WRITE_I,
  input  wire logic [3:0]          AVS_BYTEENABLE_I,
  input  wire logic [31:0]         AVS_WRITEDATA_I,
  output logic      [31:0]         AVS_READDATA_O,
  output logic                     AVS_WAITREQUEST_O,
  input  wire logic [7:0]          DIN_I,
  input  wire logic                SAFE_TORQUE_OFF_INPUT_I,
  input  wire logic                FAULT_I,
  input  wire logic                CURRENT_HEATING_LIMIT_I,
  input  wire logic                REGEN_THRESHOLD_I,
  output logic      [1:0]          DOUT_O,
  output logic                     STAGE_EN_O,
  output logic                     FAULT_RELAY_O,
  output logic      [7:0]          FUNC_ACT_O,
  output logic                     IRQ_O
);
  import diefl_pkg::*;

  localparam int unsigned FAST_CYC =
    `DIEFL_FAST_UPD_NS / `DIEFL_CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // synchronisers and update ticks
  // ----------------------------------------------------------------------
  logic [11:0] pins_s;
  logic        fast_tick;
  logic        slow_tick;

  diefl_sync #(.W(12)) u_sync (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (ARST_N_I),
    .d_i     ({REGEN_THRESHOLD_I, CURRENT_HEATING_LIMIT_I, FAULT_I,
               SAFE_TORQUE_OFF_INPUT_I, DIN_I}),
    .q_o     (pins_s)
  );

  diefl_tick #(.CYC(FAST_CYC)) u_fast (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (ARST_N_I),
    .tick_o  (fast_tick)
  );

  diefl_tick #(.CYC(SLOW_CYC)) u_slow (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (ARST_N_I),
    .tick_o  (slow_tick)
  );

  wire [7:0] din_s   = pins_s[7:0];
  wire       safe_s  = pins_s[8];
  wire       fault_s = pins_s[9];
  wire       heat_s  = pins_s[10];
  wire       regen_s = pins_s[11];
  wire       en_s    = din_s[7];       // input eight: enable only

  // ----------------------------------------------------------------------
  // bus slave: one wait state, then the transfer completes
  // ----------------------------------------------------------------------
  diefl_bus_t  bus_q;
  logic [31:0] rdata_q;
  wire         req     = AVS_READ_I | AVS_WRITE_I;
  wire         in_ack  = (bus_q == DIEFL_ACK);
  wire         wr_take = AVS_WRITE_I & in_ack;
  wire [31:0]  wmask   = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
                          {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
  wire [31:0]  wbits   = AVS_WRITEDATA_I & wmask;

  wire sel_ctrl  = (AVS_ADDRESS_I == `DIEFL_OFF_CTRL);
  wire sel_in    = (AVS_ADDRESS_I == `DIEFL_OFF_IN_CFG);
  wire sel_out   = (AVS_ADDRESS_I == `DIEFL_OFF_OUT_CFG);
  wire sel_save  = (AVS_ADDRESS_I == `DIEFL_OFF_SAVE);
  wire sel_stat  = (AVS_ADDRESS_I == `DIEFL_OFF_PIN_STAT);
  wire sel_irq   = (AVS_ADDRESS_I == `DIEFL_OFF_IRQ_STAT);
  wire sel_mask  = (AVS_ADDRESS_I == `DIEFL_OFF_IRQ_MASK);
  wire sel_latch = (AVS_ADDRESS_I == `DIEFL_OFF_LATCH);

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] m);
    return (old_v & ~m) | (new_v & m);
  endfunction : merge

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      bus_q <= DIEFL_IDLE;
    else
    begin
      case (bus_q)
        DIEFL_IDLE: bus_q <= req ? DIEFL_ACK : DIEFL_IDLE;
        DIEFL_ACK:  bus_q <= DIEFL_IDLE;
        default:    bus_q <= DIEFL_IDLE;
      endcase
    end
  end

  assign AVS_WAITREQUEST_O = req & ~in_ack;
  assign AVS_READDATA_O    = rdata_q;

  // ----------------------------------------------------------------------
  // control and configuration registers
  // ----------------------------------------------------------------------
  logic [2:0]  ctrl_q;
  logic [20:0] in_pend_q;
  logic [20:0] in_act_q;
  logic [5:0]  out_pend_q;
  logic [5:0]  out_act_q;
  diefl_irq_t  irq_q;
  diefl_irq_t  mask_q;

  wire [31:0] ctrl_wv = merge({29'h0, ctrl_q}, AVS_WRITEDATA_I, wmask);
  wire [31:0] in_wv   = merge({11'h0, in_pend_q}, AVS_WRITEDATA_I, wmask);
  wire [31:0] out_wv  = merge({26'h0, out_pend_q}, AVS_WRITEDATA_I, wmask);
  wire [31:0] mask_wv = merge({26'h0, mask_q}, AVS_WRITEDATA_I, wmask);
  wire save_go = wr_take & sel_save & wbits[`DIEFL_SAVE_GO];
  wire flt_clr = wr_take & sel_ctrl & wbits[`DIEFL_CTRL_FLT_CLR];
  wire sw_en_eff = ctrl_q[`DIEFL_CTRL_SW_EN] | ctrl_q[`DIEFL_CTRL_SW_PERM];
  wire rly_mode  = ctrl_q[`DIEFL_CTRL_RLY_MODE];
  wire cfg_dirty = (in_pend_q != in_act_q) | (out_pend_q != out_act_q);

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      ctrl_q     <= `DIEFL_CTRL_RST;
      in_pend_q  <= `DIEFL_IN_CFG_RST;
      out_pend_q <= `DIEFL_OUT_CFG_RST;
      mask_q     <= `DIEFL_IRQ_RST;
    end
    else if (wr_take)
    begin
      if (sel_ctrl)
        ctrl_q <= ctrl_wv[2:0];
      if (sel_in)
        in_pend_q <= in_wv[20:0];  // only seven fields exist
      if (sel_out)
        out_pend_q <= out_wv[5:0];
      if (sel_mask)
        mask_q <= mask_wv[5:0];
    end
  end

  // pending settings become live only on an explicit save
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      in_act_q  <= `DIEFL_IN_CFG_RST;
      out_act_q <= `DIEFL_OUT_CFG_RST;
    end
    else if (save_go)
    begin
      in_act_q  <= in_pend_q;
      out_act_q <= out_pend_q;
    end
  end

  // ----------------------------------------------------------------------
  // input sampling and function decode
  // ----------------------------------------------------------------------
  logic [1:0]  fast_q;
  logic [4:0]  slow_q;
  logic [7:0]  func_q;
  logic [7:0]  func_d;
  logic [7:0]  hit [0:6];
  logic [6:0]  on;
  wire  [6:0]  lvl = {slow_q, fast_q};

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      fast_q <= 2'h0;
      slow_q <= 5'h00;
    end
    else
    begin
      if (fast_tick)
        fast_q <= din_s[1:0];
      if (slow_tick)
        slow_q <= din_s[6:2];
    end
  end

  genvar i;
  generate
    for (i = 0; i < 7; i++)
    begin : g_in
      wire diefl_func_t code = in_act_q[3*i +: 3];
      assign on[i]  = (code != `DIEFL_FN_NONE) &
                      (lvl[i] ^ code[`DIEFL_FN_LOW_BIT]);
      assign hit[i] = on[i] ? (8'h01 << code) : 8'h00;
    end
  endgenerate

  always_comb
  begin
    func_d = 8'h00;
    for (int k = 0; k < 7; k++)
      func_d = func_d | hit[k];
  end

  // latch only follows the fast pair; slow pins would blur the stamp
  wire [7:0] fast_hit  = hit[0] | hit[1];
  wire       latch_lvl = fast_hit[`DIEFL_FN_LATCH];

  // ----------------------------------------------------------------------
  // fault latch, enable gate and relay
  // ----------------------------------------------------------------------
  logic        fault_q;
  logic        gate_q;
  logic        relay_q;
  logic        latch_prev_q;
  logic [31:0] stamp_q;
  logic [31:0] latch_q;
  logic [2:0]  prev_q;

  wire reset_req = flt_clr | (func_d[`DIEFL_FN_FLT_RESET] &
                              ~func_q[`DIEFL_FN_FLT_RESET]);
  wire fault_any = fault_q | fault_s;
  wire gate_d    = en_s & safe_s & sw_en_eff
                   & ~fault_any;
  wire relay_d   = ~fault_any & (~rly_mode | gate_d);
  wire latch_ev  = latch_lvl & ~latch_prev_q;

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      fault_q      <= 1'b0;
      gate_q       <= 1'b0;
      relay_q      <= 1'b0;
      func_q       <= 8'h00;
      latch_prev_q <= 1'b0;
      prev_q       <= 3'h0;
    end
    else
    begin
      // a new fault wins over a clear in the same cycle
      fault_q      <= fault_s | (fault_q & ~reset_req);
      gate_q       <= gate_d;
      relay_q      <= relay_d;
      func_q       <= func_d;
      latch_prev_q <= latch_lvl;
      prev_q       <= {safe_s, regen_s, heat_s};
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      stamp_q <= 32'h0000_0000;
      latch_q <= 32'h0000_0000;
    end
    else
    begin
      if (fast_tick)
        stamp_q <= stamp_q + 32'h0000_0001;
      if (latch_ev)
        latch_q <= stamp_q;
    end
  end

  // ----------------------------------------------------------------------
  // programmable outputs
  // ----------------------------------------------------------------------
  logic [1:0] dout_q;
  logic [1:0] dout_sel;
  wire  [7:0] osrc = {en_s, safe_s, regen_s, heat_s,
                      relay_q, gate_q, ~fault_q, 1'b0};

  genvar j;
  generate
    for (j = 0; j < 2; j++)
    begin : g_out
      assign dout_sel[j] = osrc[out_act_q[3*j +: 3]];
    end
  endgenerate

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      dout_q <= 2'h0;
    else if (slow_tick)
      dout_q <= dout_sel;
  end

  // ----------------------------------------------------------------------
  // interrupts and read mux
  // ----------------------------------------------------------------------
  wire [5:0] ev = {~safe_s & prev_q[2], regen_s & ~prev_q[1],
                   heat_s & ~prev_q[0], latch_ev,
                   gate_q & ~gate_d, fault_s & ~fault_q};
  wire [5:0] w1c = (wr_take & sel_irq) ? wbits[5:0] : 6'h00;

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      irq_q <= `DIEFL_IRQ_RST;
    else
      irq_q <= (irq_q & ~w1c) | ev;
  end

  wire [31:0] stat_v = {9'h000, lvl, regen_s, heat_s, cfg_dirty, fault_q,
                        relay_q, gate_q, dout_q, din_s};
  wire [31:0] rd_mux =
    sel_ctrl  ? {29'h0, ctrl_q}     :
    sel_in    ? {11'h0, in_pend_q}  :
    sel_out   ? {26'h0, out_pend_q} :
    sel_save  ? {31'h0, cfg_dirty}  :
    sel_stat  ? stat_v              :
    sel_irq   ? {26'h0, irq_q}      :
    sel_mask  ? {26'h0, mask_q}     :
    sel_latch ? latch_q             : 32'h0000_0000;

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      rdata_q <= 32'h0000_0000;
    else if (AVS_READ_I & ~in_ack)
      rdata_q <= rd_mux;
  end

  assign IRQ_O         = |(irq_q & mask_q);
  assign DOUT_O        = dout_q;
  assign STAGE_EN_O    = gate_q;
  assign FAULT_RELAY_O = relay_q;
  assign FUNC_ACT_O    = func_q;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!ARST_N_I);

  logic saved_q;
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      saved_q <= 1'b0;
    else if (save_go)
      saved_q <= 1'b1;
  end

  AST_FAST_RATE: assert property (!fast_tick |=> $stable(fast_q))
    else $error("fast inputs moved without a 2 us tick");
  AST_SLOW_RATE: assert property (!slow_tick |=> $stable(slow_q))
    else $error("slow inputs moved without a 250 us tick");
  AST_UNASSIGNED: assert property (!saved_q |-> func_q == 8'h00)
    else $error("function active before any save");
  AST_SAVE_IN: assert property (!save_go |=> $stable(in_act_q))
    else $error("input assignment changed without save");
  AST_SAFE_BLOCK: assert property (!safe_s |=> !STAGE_EN_O)
    else $error("stage enabled without safe torque off");
  AST_EN_LOW: assert property (!en_s |=> !STAGE_EN_O)
    else $error("stage enabled with enable input low");
  AST_SW_AND: assert property (!sw_en_eff |=> !STAGE_EN_O)
    else $error("stage enabled without software enable");
  AST_DOUT_RATE: assert property (!slow_tick |=> $stable(DOUT_O))
    else $error("outputs moved without a 250 us tick");
  AST_SAVE_OUT: assert property (!save_go |=> $stable(out_act_q))
    else $error("output assignment changed without save");
  AST_RELAY_MODE0: assert property (!rly_mode
    && !fault_any |=> FAULT_RELAY_O)
    else $error("relay open without fault in mode zero");
  AST_FAULT_OFF: assert property (fault_s |=> !STAGE_EN_O && !FAULT_RELAY_O)
    else $error("fault did not open relay and stop stage");
  AST_GATE_ON: assert property (en_s && safe_s && sw_en_eff
    && !fault_any |=> STAGE_EN_O)
    else $error("stage off with all enable terms true");

  COV_STAGE_ON: cover property ($rose(STAGE_EN_O));
  COV_FAULT_TRIP: cover property (STAGE_EN_O ##1 !FAULT_RELAY_O);
  COV_LATCH: cover property (latch_ev);
  COV_IRQ: cover property ($rose(IRQ_O));
endmodule : diefl_top

// File: verilog/diefl_consts.svh
/*
  constants of the drive digital i/o, enable and fault block: register
  offsets, field positions, reset values, function codes and timing.
  assumes a 100 MHz system clock and a 32-bit avalon-mm register bus.
*/
`ifndef DIEFL_CONSTS_SVH
`define DIEFL_CONSTS_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define DIEFL_CLK_PERIOD_NS 10
`define DIEFL_FAST_UPD_NS   2000
`define DIEFL_SLOW_UPD_NS   250000

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define DIEFL_OFF_CTRL      6'h00
`define DIEFL_OFF_IN_CFG    6'h04
`define DIEFL_OFF_OUT_CFG   6'h08
`define DIEFL_OFF_SAVE      6'h0c
`define DIEFL_OFF_PIN_STAT  6'h10
`define DIEFL_OFF_IRQ_STAT  6'h14
`define DIEFL_OFF_IRQ_MASK  6'h18
`define DIEFL_OFF_LATCH     6'h1c

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define DIEFL_CTRL_SW_EN    0
`define DIEFL_CTRL_SW_PERM  1
`define DIEFL_CTRL_RLY_MODE 2
`define DIEFL_CTRL_FLT_CLR  3
`define DIEFL_SAVE_GO       0
`define DIEFL_CTRL_RST      3'h0
`define DIEFL_IN_CFG_RST    21'h000000
`define DIEFL_OUT_CFG_RST   6'h00
`define DIEFL_IRQ_RST       6'h00
`define DIEFL_FN_W          3

// ----------------------------------------------------------------------
// input function codes; codes with bit 2 set are active low
// ----------------------------------------------------------------------
`define DIEFL_FN_NONE       3'h0
`define DIEFL_FN_LATCH      3'h1
`define DIEFL_FN_GEAR       3'h2
`define DIEFL_FN_FLT_RESET  3'h3
`define DIEFL_FN_LOW_BIT    2

// ----------------------------------------------------------------------
// interrupt status bits
// ----------------------------------------------------------------------
`define DIEFL_IRQ_FAULT     0
`define DIEFL_IRQ_GATE_OFF  1
`define DIEFL_IRQ_LATCH     2
`define DIEFL_IRQ_HEAT      3
`define DIEFL_IRQ_REGEN     4
`define DIEFL_IRQ_SAFE_DROP 5

`endif

// File: verilog/diefl_pkg.sv
/*
  types of the drive digital i/o, enable and fault block.
  assumes diefl_consts.svh is on the include path.
*/
`include "diefl_consts.svh"

package diefl_pkg;
  typedef logic [5:0]                 diefl_addr_t;
  typedef logic [`DIEFL_FN_W-1:0]     diefl_func_t;
  typedef logic [5:0]                 diefl_irq_t;
  typedef enum logic [0:0] {DIEFL_IDLE, DIEFL_ACK} diefl_bus_t;
endpackage : diefl_pkg

// File: verilog/diefl_sync.sv
/*
  two-stage synchroniser for a vector of unrelated level inputs.
  assumes each bit is a slow level; no bus coherency across bits.
*/
`timescale 1ns/100ps

module diefl_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  genvar b;
  generate
    for (b = 0; b < W; b++)
    begin : g_bit
      always_ff @(posedge clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          meta_q[b] <= 1'b0;
          q_o[b]    <= 1'b0;
        end
        else
        begin
          meta_q[b] <= d_i[b];
          q_o[b]    <= meta_q[b];
        end
      end
    end
  endgenerate
endmodule : diefl_sync

// File: verilog/diefl_tick.sv
/*
  free-running divider giving one-cycle tick every CYC clocks.
  assumes CYC of at least 1.
*/
`timescale 1ns/100ps

module diefl_tick #(
  parameter int unsigned CYC = 2
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  output logic      tick_o
);
  localparam int unsigned CW = (CYC > 1) ? $clog2(CYC) : 1;

  logic [CW-1:0] cnt_q;
  wire           wrap = (cnt_q == CW'(CYC - 1));

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      cnt_q  <= wrap ? '0 : cnt_q + 1'b1;
      tick_o <= wrap;
    end
  end
endmodule : diefl_tick

// File: testbench/diefl_ext_model.sv
/*
  model of the switches, sensors and safety wiring at the pins.
  assumes the bench sets the wanted levels on the want_ inputs.
*/
`timescale 1ns/100ps

module diefl_ext_model
(
  input  wire logic       clk_i,
  input  wire logic [7:0] want_din_i,
  input  wire logic [3:0] want_misc_i,
  output logic      [7:0] din_o,
  output logic            safe_o,
  output logic            fault_o,
  output logic            heat_o,
  output logic            regen_o
);
  // ------------------------------------------------------------------
  // contacts
  // ------------------------------------------------------------------
  // levels settle one clock after the bench asks, never mid-cycle
  always_ff @(posedge clk_i)
  begin
    din_o                             <= want_din_i;
    {regen_o, heat_o, fault_o, safe_o} <= want_misc_i;
  end
endmodule : diefl_ext_model

// File: testbench/tb_drive_io_enable_fault_logic.sv
/*
  self-checking bench of the i/o, enable gate and fault relay block.
  assumes the external model above and a short slow-tick parameter.
*/
`timescale 1ns/100ps
`include "diefl_consts.svh"

module tb_drive_io_enable_fault_logic;
  import diefl_pkg::*;
  localparam int SLOW = 50;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  diefl_addr_t addr = 6'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        waitreq;
  logic [1:0]  dout;
  logic        stage;
  logic        relay;
  logic [7:0]  fact;
  logic        irq;
  logic [7:0]  want_din = 8'h00;
  logic [3:0]  want_misc = 4'h0;
  logic [7:0]  din;
  logic        safe_off;
  logic        fault;
  logic        heat;
  logic        regen;
  int          error_cnt = 0;
  int          cmp_count = 0;

  always #5 clk = ~clk;

  diefl_ext_model u_ext (.clk_i(clk), .want_din_i(want_din),
    .want_misc_i(want_misc), .din_o(din), .safe_o(safe_off),
    .fault_o(fault),
    .heat_o(heat), .regen_o(regen));

  diefl_top #(.SLOW_CYC(SLOW)) u_dut (.SYS_CLK_I(clk), .ARST_N_I(arst_n),
    .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_BYTEENABLE_I(4'hf), .AVS_WRITEDATA_I(wdata),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .DIN_I(din),
    .SAFE_TORQUE_OFF_INPUT_I(safe_off), .FAULT_I(fault),
    .CURRENT_HEATING_LIMIT_I(heat), .REGEN_THRESHOLD_I(regen),
    .DOUT_O(dout), .STAGE_EN_O(stage), .FAULT_RELAY_O(relay),
    .FUNC_ACT_O(fact), .IRQ_O(irq));

  // ------------------------------------------------------------------
  // bus and compare helpers
  // ------------------------------------------------------------------
  task automatic bus(input logic w, input diefl_addr_t a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    rd    <= ~w;
    wr    <= w;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitreq !== 1'b0 && n < 100);
    q  = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 100)
      error_cnt++;
  endtask : bus

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr_reg(diefl_addr_t a, logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr_reg

  task automatic rd_chk(string name, diefl_addr_t a, logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(name, e, q);
  endtask : rd_chk

  // pin to gate is three edges plus one in the model
  task automatic pins(logic [7:0] d, logic [3:0] m);
    @(posedge clk);
    want_din  <= d;
    want_misc <= m;
    repeat (8) @(posedge clk);
  endtask : pins

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    chk("func_act", 8'h00, fact);
    chk("stage", 1'b0, stage);
    rd_chk("ctrl", `DIEFL_OFF_CTRL, 32'h0);
    rd_chk("in_cfg", `DIEFL_OFF_IN_CFG, 32'h0);
    rd_chk("out_cfg", `DIEFL_OFF_OUT_CFG, 32'h0);
    rd_chk("unmapped", 6'h20, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_gate;
    wr_reg(`DIEFL_OFF_CTRL, 32'h1);
    pins(8'h80, 4'h1);
    chk("stage on", 1'b1, stage);
    chk("relay mode0", 1'b1, relay);
    pins(8'h80, 4'h0);
    chk("stage no safe", 1'b0, stage);
    pins(8'h00, 4'h1);
    chk("stage no en", 1'b0, stage);
    wr_reg(`DIEFL_OFF_CTRL, 32'h0);
    pins(8'h80, 4'h1);
    chk("stage no sw", 1'b0, stage);
    wr_reg(`DIEFL_OFF_CTRL, 32'h2);
    pins(8'h80, 4'h1);
    chk("stage perm", 1'b1, stage);
    pins(8'h80, 4'hd);
    chk("relay warn", 1'b1, relay);
    chk("stage warn", 1'b1, stage);
    $display("test gate done");
  endtask : t_gate

  task automatic t_fault;
    wr_reg(`DIEFL_OFF_IRQ_MASK, 32'h1);
    pins(8'h80, 4'h3);
    chk("relay fault", 1'b0, relay);
    chk("stage fault", 1'b0, stage);
    chk("irq fault", 1'b1, irq);
    pins(8'h80, 4'h1);
    chk("stage latched", 1'b0, stage);
    wr_reg(`DIEFL_OFF_CTRL, 32'ha);
    wr_reg(`DIEFL_OFF_IRQ_STAT, 32'h1);
    pins(8'h80, 4'h1);
    chk("stage cleared", 1'b1, stage);
    chk("irq cleared", 1'b0, irq);
    wr_reg(`DIEFL_OFF_CTRL, 32'h6);
    pins(8'h00, 4'h1);
    chk("relay mode1", 1'b0, relay);
    pins(8'h80, 4'h1);
    chk("relay mode1 on", 1'b1, relay);
    $display("test fault done");
  endtask : t_fault

  task automatic t_inputs;
    wr_reg(`DIEFL_OFF_IRQ_STAT, 32'h0000_003f);
    wr_reg(`DIEFL_OFF_IN_CFG, 32'h0000_0081);
    rd_chk("dirty", `DIEFL_OFF_SAVE, 32'h1);
    pins(8'h85, 4'h1);
    repeat (SLOW + 210) @(posedge clk);
    chk("unsaved", 8'h00, fact);
    wr_reg(`DIEFL_OFF_SAVE, 32'h1);
    pins(8'h80, 4'h1);
    pins(8'h85, 4'h1);
    repeat (SLOW + 210) @(posedge clk);
    chk("saved", 8'h06, fact);
    rd_chk("latch irq", `DIEFL_OFF_IRQ_STAT, 32'h4);
    wr_reg(`DIEFL_OFF_IN_CFG, 32'h0000_0181);
    wr_reg(`DIEFL_OFF_SAVE, 32'h1);
    pins(8'h81, 4'h1);
    repeat (SLOW + 10) @(posedge clk);
    chk("low active", 8'h42, fact);
    pins(8'h85, 4'h1);
    repeat (SLOW + 10) @(posedge clk);
    chk("low idle", 8'h02, fact);
    wr_reg(`DIEFL_OFF_IN_CFG, 32'hffff_ffff);
    rd_chk("in8 fixed", `DIEFL_OFF_IN_CFG, 32'h001f_ffff);
    pins(8'h80, 4'h3);
    pins(8'h80, 4'h1);
    chk("fault held", 1'b0, stage);
    wr_reg(`DIEFL_OFF_IN_CFG, 32'h0000_0600);
    wr_reg(`DIEFL_OFF_SAVE, 32'h1);
    pins(8'h88, 4'h1);
    repeat (SLOW + 10) @(posedge clk);
    chk("reset fn", 8'h08, fact);
    chk("stage by reset fn", 1'b1, stage);
    $display("test inputs done");
  endtask : t_inputs

  task automatic t_outputs;
    wr_reg(`DIEFL_OFF_OUT_CFG, 32'h0000_003e);
    repeat (SLOW + 10) @(posedge clk);
    chk("dout unsaved", 2'b00, dout);
    wr_reg(`DIEFL_OFF_SAVE, 32'h1);
    repeat (SLOW + 10) @(posedge clk);
    chk("dout safe", 2'b11, dout);
    pins(8'h85, 4'h0);
    repeat (SLOW + 10) @(posedge clk);
    chk("dout no safe", 2'b10, dout);
    $display("test outputs done");
  endtask : t_outputs

  // ------------------------------------------------------------------
  // run control
  // ------------------------------------------------------------------
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  // whole run is under two thousand cycles; a hang stops well past it
  initial
  begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    complete_run();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_gate();
    t_fault();
    t_inputs();
    t_outputs();
    complete_run();
  end
endmodule : tb_drive_io_enable_fault_logic
